// [logic/pwio_bus_slave.v]
// Avalon-MM slave front end: waitrequest timing, read data capture.
// Assumes a master that holds its request until waitrequest is seen low.
`timescale 1ns/1ps
`include "pwio_consts.vh"

module pwio_bus_slave #(
    parameter ADDR_W = 5
) (
    input wire clock,                      // System clock
    input wire rst,                        // Synchronous reset, active high
    input wire [ADDR_W-1:0] avsAddress,    // Byte address
    input wire avsRead,                    // Read request
    input wire avsWrite,                   // Write request
    input wire [31:0] avsWritedata,        // Write data
    input wire [3:0] avsByteenable,        // Byte lanes
    output reg [31:0] avsReaddata,         // Read data, registered
    output reg avsWaitrequest,             // Stall, registered
    output wire [2:0] regIndex,            // Decoded word index
    output wire rdStb,                     // Read completes this edge
    output wire wrStb,                     // Write completes this edge
    output wire [15:0] wrData,             // Low half of write data
    output wire [1:0] wrBe,                // Low two byte enables
    input wire [15:0] rdValue              // Value of the addressed register
);

    ////////////////////////////////////////////////////////////////////////
    wire busReq;     // Any request present
    wire inRange;    // Address falls on a mapped word

    assign busReq = avsRead | avsWrite;
    assign regIndex = avsAddress[4:2];
    assign inRange = (avsAddress[4:2] <= `PWIO_IDX_CONFIG);
    // Strobes fire only at the edge where the master sees the stall drop
    assign rdStb = avsRead & ~avsWaitrequest;
    assign wrStb = avsWrite & ~avsWaitrequest;
    assign wrData = avsWritedata[15:0];
    assign wrBe = avsByteenable[1:0];

    ////////////////////////////////////////////////////////////////////////
    // One stall cycle, then one ready cycle; data captured while stalling
    always @(posedge clock) begin
        if (rst) begin
            avsWaitrequest <= 1'b1;
            avsReaddata <= `PWIO_RST_BUS;
        end else if (busReq && avsWaitrequest) begin
            avsWaitrequest <= 1'b0;
            // Unmapped words read as zero, upper half always zero
            avsReaddata <= (avsRead && inRange) ? {16'h0000, rdValue} : `PWIO_RST_BUS;
        end else begin
            avsWaitrequest <= 1'b1;
        end
    end

endmodule

// [logic/pwio_consts.vh]
// Constants of the parallel word I/O block: offsets, bit fields, resets.
// Assumes inclusion by bare name from every design file of the block.
`ifndef PWIO_CONSTS_VH
`define PWIO_CONSTS_VH

// Register word indices (byte address = 4 * index)
`define PWIO_IDX_STATUS 3'h0
`define PWIO_IDX_INPUT 3'h1
`define PWIO_IDX_OUTPUT 3'h2
`define PWIO_IDX_CONFIG 3'h3

// Status register bit positions
`define PWIO_ST_OUT_FLAG 15
`define PWIO_ST_OUT_IE 14
`define PWIO_ST_OUT_FORCE 13
`define PWIO_ST_IN_FLAG 7
`define PWIO_ST_IN_IE 6
`define PWIO_ST_IN_FORCE 5

// Configuration register bit positions
`define PWIO_CFG_BUFFERED 0
`define PWIO_CFG_SOFT_INIT 1

// Reset values
`define PWIO_RST_WORD 16'h0000
`define PWIO_RST_BUS 32'h0000_0000
`define PWIO_RST_CFG 1'h0

`endif

// [logic/pwio_top.v]
// Parallel word I/O port: 16 lines in, 16 lines out, handshakes,
// status with flags and interrupt enables, request/accept per direction.
// Assumes external lines synchronous to clock and a host that answers
// each interrupt request with a one-cycle accept pulse.
`timescale 1ns/1ps
`include "pwio_consts.vh"

module pwio_top #(
    parameter DATA_W = 16,
    parameter ADDR_W = 5
) (
    input wire clock,                          // System clock, 100 MHz
    input wire rst,                            // Synchronous reset, active high
    input wire [ADDR_W-1:0] avsAddress,        // Avalon byte address
    input wire avsRead,                        // Avalon read
    input wire avsWrite,                       // Avalon write
    input wire [31:0] avsWritedata,            // Avalon write data
    input wire [3:0] avsByteenable,            // Avalon byte enables
    output wire [31:0] avsReaddata,            // Avalon read data
    output wire avsWaitrequest,                // Avalon stall
    input wire [DATA_W-1:0] inbound_lines,     // Parallel data from far side
    input wire extDataReady,                   // Far side has data, level
    input wire extAcceptedA,                   // Far side took output, line A
    input wire extAcceptedB,                   // Far side took output, line B
    output reg [DATA_W-1:0] outbound_lines,    // Parallel data to far side
    output reg lowDataReady,                   // Low byte loaded, pulse
    output reg highDataReady,                  // High byte loaded, pulse
    output reg inDataAccepted,                 // Input read, pulse
    output reg system_init_out,                // System_init_out to far side
    output reg inIrqReq,                       // Input interrupt request
    input wire inIrqAck,                       // Host accepts input request
    output reg outIrqReq,                      // Output interrupt request
    input wire outIrqAck                       // Host accepts output request
);

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane merge of a 16-bit write into a held word
    function [15:0] mergeBytes;
        input [15:0] oldVal;
        input [15:0] newVal;
        input [1:0] be;
        begin
            mergeBytes = {be[1] ? newVal[15:8] : oldVal[15:8],
                          be[0] ? newVal[7:0] : oldVal[7:0]};
        end
    endfunction

    // Mask of written-as-one bits, limited to enabled lanes
    function [15:0] laneOnes;
        input [15:0] newVal;
        input [1:0] be;
        begin
            laneOnes = newVal & {{8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus front end
    wire [2:0] regIndex;       // Word addressed
    wire rdStb;                // Read completes
    wire wrStb;                // Write completes
    wire [15:0] wrData;        // Write data, low half
    wire [1:0] wrBe;           // Lanes of low half
    reg [15:0] rdValue;        // Mux into the front end

    pwio_bus_slave #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .clock(clock),
        .rst(rst),
        .avsAddress(avsAddress),
        .avsRead(avsRead),
        .avsWrite(avsWrite),
        .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest),
        .regIndex(regIndex),
        .rdStb(rdStb),
        .wrStb(wrStb),
        .wrData(wrData),
        .wrBe(wrBe),
        .rdValue(rdValue)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register state
    reg outFlag_q;             // Output flag
    reg outIe_q;               // Output interrupt enable
    reg inFlag_q;              // Input flag
    reg inIe_q;                // Input interrupt enable
    reg bufMode_q;             // Buffered-bit input mode
    reg [15:0] inBuf_q;        // Buffered input bits
    reg readyPrev_q;           // Last ready level, for edge detect
    reg accPrev_q;             // Last accepted level, for edge detect

    // Decoded accesses
    wire wrStatus;             // Status write
    wire wrInput;              // Input register write
    wire wrOutput;             // Output register write
    wire wrConfig;             // Configuration write
    wire rdInput;              // Input register read
    wire softInit;             // Software system_init_out request
    wire initAll;              // Any initialization this cycle
    wire readyEdge;            // Rising edge of far-side ready
    wire accLevel;             // Either accepted line high
    wire accEdge;              // Rising edge of accepted
    wire [15:0] newBits;       // Buffer bits newly set
    wire inEvent;              // Input event that may interrupt
    wire outEvent;             // Output event that may interrupt
    wire inForce;              // Maintenance input request
    wire outForce;             // Maintenance output request

    assign wrStatus = wrStb && (regIndex == `PWIO_IDX_STATUS);
    assign wrInput = wrStb && (regIndex == `PWIO_IDX_INPUT);
    assign wrOutput = wrStb && (regIndex == `PWIO_IDX_OUTPUT);
    assign wrConfig = wrStb && (regIndex == `PWIO_IDX_CONFIG);
    assign rdInput = rdStb && (regIndex == `PWIO_IDX_INPUT);
    assign softInit = wrConfig && wrBe[0] && wrData[`PWIO_CFG_SOFT_INIT];
    // Reset and software init act alike on control state
    assign initAll = rst | softInit;

    // Far side delivers one edge per transfer; a held level counts once
    assign readyEdge = extDataReady & ~readyPrev_q;
    // Either of the two accepted lines may be wired                  
    assign accLevel = extAcceptedA | extAcceptedB;
    assign accEdge = accLevel & ~accPrev_q;

    // Any bit rising into the buffer while in buffered mode
    assign newBits = inbound_lines & ~inBuf_q;
    assign inEvent = bufMode_q ? (|newBits) : readyEdge;
    assign outEvent = accEdge;

    // Maintenance bits: a one written forces a request
    assign inForce = wrStatus && wrBe[0] && wrData[`PWIO_ST_IN_FORCE];
    assign outForce = wrStatus && wrBe[1] && wrData[`PWIO_ST_OUT_FORCE];

    ////////////////////////////////////////////////////////////////////////
    // Edge detector history
    always @(posedge clock) begin
        if (rst) begin
            readyPrev_q <= 1'b0;
            accPrev_q <= 1'b0;
        end else begin
            readyPrev_q <= extDataReady;
            accPrev_q <= accLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input flag: set on ready edge, cleared by a low-byte status write
    always @(posedge clock) begin
        if (initAll) begin
            inFlag_q <= 1'b0;
        end else if (readyEdge) begin
            // Set wins over a clear in the same cycle
            inFlag_q <= 1'b1;
        end else if (wrStatus && wrBe[0]) begin
            // Software rearm clears the flag                         
            inFlag_q <= 1'b0;
        end
    end

    // Output flag: set on accepted edge, cleared by a high-byte write
    always @(posedge clock) begin
        if (initAll) begin
            outFlag_q <= 1'b0;
        end else if (outEvent) begin
            outFlag_q <= 1'b1;
        end else if (wrStatus && wrBe[1]) begin
            outFlag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input enable: written by software, dropped when host accepts
    always @(posedge clock) begin
        if (initAll) begin
            inIe_q <= 1'b0;
        end else if (wrStatus && wrBe[0]) begin
            // A write in the accept cycle is the newer intent
            inIe_q <= wrData[`PWIO_ST_IN_IE];
        end else if (inIrqAck && inIrqReq) begin
            inIe_q <= 1'b0;
        end
    end

    // Output enable: written by software, dropped when host accepts
    always @(posedge clock) begin
        if (initAll) begin
            outIe_q <= 1'b0;
        end else if (wrStatus && wrBe[1]) begin
            outIe_q <= wrData[`PWIO_ST_OUT_IE];
        end else if (outIrqAck && outIrqReq) begin
            outIe_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input request: raised by enabled event or force, held until accepted
    always @(posedge clock) begin
        if (initAll) begin
            inIrqReq <= 1'b0;
        end else if ((inEvent && inIe_q) || inForce) begin
            inIrqReq <= 1'b1;
        end else if (inIrqAck) begin
            inIrqReq <= 1'b0;
        end
    end

    // Output request: same shape as the input side
    always @(posedge clock) begin
        if (initAll) begin
            outIrqReq <= 1'b0;
        end else if ((outEvent && outIe_q) || outForce) begin
            outIrqReq <= 1'b1;
        end else if (outIrqAck) begin
            outIrqReq <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode selection; software init does not alter the mode
    always @(posedge clock) begin
        if (rst) begin
            bufMode_q <= `PWIO_RST_CFG;
        end else if (wrConfig && wrBe[0]) begin
            bufMode_q <= wrData[`PWIO_CFG_BUFFERED];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffered input bits: lines set, one-bits of a write clear.
    // Software must clear before the far side sends again, or old
    // ones merge with the new word.
    always @(posedge clock) begin
        if (rst) begin
            inBuf_q <= `PWIO_RST_WORD;
        end else if (wrInput) begin
            // A line high in the clear cycle keeps its bit set
            inBuf_q <= (inBuf_q & ~laneOnes(wrData, wrBe)) | inbound_lines;
        end else if (bufMode_q) begin
            inBuf_q <= inBuf_q | inbound_lines;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output register, byte or word loads, driven straight to the lines
    always @(posedge clock) begin
        if (rst) begin
            outbound_lines <= `PWIO_RST_WORD;
        end else if (wrOutput) begin
            outbound_lines <= mergeBytes(outbound_lines, wrData, wrBe);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Handshake strobes, one clock each, in the bus clock domain
    always @(posedge clock) begin
        if (rst) begin
            lowDataReady <= 1'b0;
            highDataReady <= 1'b0;
            inDataAccepted <= 1'b0;
        end else begin
            // Word write drives both lanes, so both strobes fire
            lowDataReady <= wrOutput && wrBe[0];
            highDataReady <= wrOutput && wrBe[1];
            // Tells the far side the lines were taken
            inDataAccepted <= rdInput;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System_init_out line: high through reset and for a soft init cycle
    always @(posedge clock) begin
        if (rst) begin
            system_init_out <= 1'b1;
        end else begin
            system_init_out <= softInit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unused bits stay zero
    always @* begin
        rdValue = 16'h0000;
        case (regIndex)
            `PWIO_IDX_STATUS: begin
                rdValue[`PWIO_ST_OUT_FLAG] = outFlag_q;
                rdValue[`PWIO_ST_OUT_IE] = outIe_q;
                rdValue[`PWIO_ST_IN_FLAG] = inFlag_q;
                rdValue[`PWIO_ST_IN_IE] = inIe_q;
            end
            `PWIO_IDX_INPUT: begin
                // Direct lines unless the buffered path is chosen
                rdValue = bufMode_q ? inBuf_q : inbound_lines;
            end
            `PWIO_IDX_OUTPUT: begin
                rdValue = outbound_lines;
            end
            `PWIO_IDX_CONFIG: begin
                rdValue[`PWIO_CFG_BUFFERED] = bufMode_q;
            end
            default: begin
                rdValue = 16'h0000;
            end
        endcase
    end

endmodule

// [verif/pwio_far_model.sv]
// Far-side device model: answers byte strobes, presents input words.
// Assumes the port's clock and reset; the bench steers it by ports.
`timescale 1ns/1ps
module pwio_far_model (
    input wire clock, // System clock
    input wire rst, // Synchronous reset
    input wire [15:0] outbound_lines, // Port output lines
    input wire lowDataReady, // Low byte strobe
    input wire highDataReady, // High byte strobe
    input wire inDataAccepted, // Input read strobe
    input wire sendReq, // Present sendWord now
    input wire [15:0] sendWord, // Word to present
    input wire useLineB, // Answer on line B
    input wire slow, // Answer late
    output reg [15:0] inbound_lines, // Data to port
    output reg extDataReady, // Data valid
    output reg extAcceptedA, // Output taken, line A
    output reg extAcceptedB, // Output taken, line B
    output reg [15:0] gotWord, // Last word taken
    output reg [7:0] loCnt, // Low strobes seen
    output reg [7:0] hiCnt, // High strobes seen
    output reg [7:0] takenCnt // Input reads seen
);
reg [3:0] waitCnt_q; // Cycles until accept pulse
reg pend_q; // Data placed, ready due
////////////////////////////////////////////////////////////
// One process: accept lines idle low, pulse for one cycle
always @(posedge clock) begin
    extAcceptedA <= 1'b0;
    extAcceptedB <= 1'b0;
    if (rst) begin
        inbound_lines <= 16'h0000;
        extDataReady <= 1'b0;
        pend_q <= 1'b0;
        waitCnt_q <= 4'h0;
        gotWord <= 16'h0000;
        loCnt <= 8'h00;
        hiCnt <= 8'h00;
        takenCnt <= 8'h00;
    end else begin
        // Read the lines on a byte strobe, answer soon or late
        if (lowDataReady || highDataReady) begin
            gotWord <= outbound_lines;
            loCnt <= loCnt + {7'h00, lowDataReady};
            hiCnt <= hiCnt + {7'h00, highDataReady};
            waitCnt_q <= slow ? 4'h6 : 4'h1;
        end else if (waitCnt_q != 4'h0) begin
            waitCnt_q <= waitCnt_q - 4'h1;
        end
        // Accept pulse on either line, chosen by the bench
        if (waitCnt_q == 4'h1) begin
            extAcceptedA <= !useLineB;
            extAcceptedB <= useLineB;
        end
        // Data first, ready a cycle later so it is valid
        if (sendReq) begin
            inbound_lines <= sendWord;
            extDataReady <= 1'b0;
            pend_q <= 1'b1;
        end else if (pend_q) begin
            extDataReady <= 1'b1;
            pend_q <= 1'b0;
        end
        // Port has read the lines: withdraw ready
        if (inDataAccepted) begin
            extDataReady <= 1'b0;
            takenCnt <= takenCnt + 8'h01;
        end
    end
end
endmodule

// [verif/pwio_top_assertions.sv]
// Checker for the parallel word I/O port, watching top ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module pwio_checker #(
    parameter DATA_W = 16,
    parameter ADDR_W = 5
) (
    input wire clock, // System clock
    input wire rst, // Synchronous reset
    input wire [ADDR_W-1:0] avsAddress, // Byte address
    input wire avsRead, // Read request
    input wire avsWrite, // Write request
    input wire [31:0] avsWritedata, // Write data
    input wire [3:0] avsByteenable, // Byte lanes
    input wire [31:0] avsReaddata, // Read data
    input wire avsWaitrequest, // Stall
    input wire [DATA_W-1:0] inbound_lines, // Far side data
    input wire extDataReady, // Far side ready
    input wire extAcceptedA, // Accept line A
    input wire extAcceptedB, // Accept line B
    input wire [DATA_W-1:0] outbound_lines, // Output lines
    input wire lowDataReady, // Low byte strobe
    input wire highDataReady, // High byte strobe
    input wire inDataAccepted, // Input read strobe
    input wire system_init_out, // System_init_out line
    input wire inIrqReq, // Input request
    input wire inIrqAck, // Input accept
    input wire outIrqReq, // Output request
    input wire outIrqAck // Output accept
);
default clocking cb @(posedge clock); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////
// Last samples of far-side lines, so edges can be told apart
reg accPrev_q;
reg rdyPrev_q;
reg [DATA_W-1:0] inPrev_q;
always @(posedge clock) begin
    accPrev_q <= extAcceptedA | extAcceptedB;
    rdyPrev_q <= extDataReady;
    inPrev_q <= inbound_lines;
end
wire [2:0] idx = avsAddress[4:2]; // Word index
wire wrOk = avsWrite && !avsWaitrequest; // Write completes
wire rdOk = avsRead && !avsWaitrequest; // Read completes
wire accRise = (extAcceptedA | extAcceptedB) && !accPrev_q; // Output taken
// Ready edge or any line rising: either may be an input event
wire inEvt = (extDataReady && !rdyPrev_q) || (|(inbound_lines & ~inPrev_q));
wire stLo = wrOk && idx == 3'h0 && avsByteenable[0]; // Status low lane
wire stHi = wrOk && idx == 3'h0 && avsByteenable[1]; // Status high lane
wire outLo = wrOk && idx == 3'h2 && avsByteenable[0]; // Output low load
wire outHi = wrOk && idx == 3'h2 && avsByteenable[1]; // Output high load
a_low_strobe: assert property (outLo |=> lowDataReady ##1 !lowDataReady)
    else $error("low byte strobe wrong");
a_high_strobe: assert property (outHi |=> highDataReady ##1 !highDataReady)
    else $error("high byte strobe wrong");
a_strobe_cause: assert property ((lowDataReady || highDataReady) |-> $past(outLo || outHi))
    else $error("byte strobe without load");
a_accept_pulse: assert property (rdOk && idx == 3'h1 |=> inDataAccepted ##1 !inDataAccepted)
    else $error("input accepted strobe wrong");
a_out_lines: assert property (outLo && outHi |=> outbound_lines == $past(avsWritedata[15:0]))
    else $error("output lines differ from word");
a_upper_zero: assert property (rdOk |-> avsReaddata[31:16] == 16'h0000)
    else $error("upper read data not zero");
a_in_cause: assert property ($rose(inIrqReq) |-> $past(inEvt || (stLo && avsWritedata[5])))
    else $error("input request without cause");
a_out_cause: assert property ($rose(outIrqReq) |-> $past(accRise || (stHi && avsWritedata[13])))
    else $error("output request without cause");
a_in_ack: assert property (inIrqReq && inIrqAck && !inEvt && !stLo |=> !inIrqReq)
    else $error("input request kept after accept");
a_out_ack: assert property (outIrqReq && outIrqAck && !accRise && !stHi |=> !outIrqReq)
    else $error("output request kept after accept");
a_init_release: assert property ($fell(rst) |-> system_init_out ##1 !system_init_out)
    else $error("system_init_out line wrong at reset release");
a_init_soft: assert property (wrOk && idx == 3'h3 && avsByteenable[0] && avsWritedata[1] |=> system_init_out)
    else $error("software system_init_out not seen");
c_out_ack: cover property (outIrqReq && outIrqAck);
c_in_ack: cover property (inIrqReq && inIrqAck);
c_both_bytes: cover property (lowDataReady && highDataReady);
endmodule
bind pwio_top pwio_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_chk (.clock, .rst, .avsAddress,
    .avsRead, .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest,
    .inbound_lines, .extDataReady, .extAcceptedA, .extAcceptedB, .outbound_lines,
    .lowDataReady, .highDataReady, .inDataAccepted, .system_init_out, .inIrqReq,
    .inIrqAck, .outIrqReq, .outIrqAck);

// [verif/pwio_top_bench.sv]
// Self-checking bench of the parallel word I/O port, acting as host.
// Assumes the port, its checker and the far-side model are compiled.
`timescale 1ns/1ps
module pwio_top_bench;
reg clock = 1'b0;
reg rst = 1'b1;
reg [4:0] avsAddress = 5'h00;
reg avsRead = 1'b0;
reg avsWrite = 1'b0;
reg [31:0] avsWritedata = 32'h0000_0000;
reg [3:0] avsByteenable = 4'h0;
reg inIrqAck = 1'b0;
reg outIrqAck = 1'b0;
reg sendReq = 1'b0;
reg [15:0] sendWord = 16'h0000;
reg useLineB = 1'b0, slow = 1'b0;
wire [31:0] avsReaddata;
wire [15:0] inbound_lines, outbound_lines, gotWord;
wire [7:0] loCnt, hiCnt, takenCnt;
wire avsWaitrequest, extDataReady, extAcceptedA, extAcceptedB, lowDataReady, highDataReady;
wire inDataAccepted, system_init_out, inIrqReq, outIrqReq;
int errorCnt = 0;
int nCompared = 0;
logic [31:0] rnd = 32'h0001_18B4; // Seed 71860
logic [15:0] expQ[$]; // Expected read data, oldest first
logic [15:0] w;
integer i;
always #5 clock = ~clock;
pwio_top i_dut (.clock, .rst, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsByteenable, .avsReaddata, .avsWaitrequest, .inbound_lines, .extDataReady,
    .extAcceptedA, .extAcceptedB, .outbound_lines, .lowDataReady, .highDataReady,
    .inDataAccepted, .system_init_out, .inIrqReq, .inIrqAck, .outIrqReq, .outIrqAck);
pwio_far_model i_far (.clock, .rst, .outbound_lines, .lowDataReady, .highDataReady,
    .inDataAccepted, .sendReq, .sendWord, .useLineB, .slow, .inbound_lines, .extDataReady,
    .extAcceptedA, .extAcceptedB, .gotWord, .loCnt, .hiCnt, .takenCnt);
////////////////////////////////////////////////////////////
function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
        errorCnt++;
        $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
endtask
// Avalon cycle: hold everything until waitrequest is sampled low
task automatic bus(input logic wr, input logic [2:0] idx, input logic [1:0] be,
                   input logic [15:0] d);
    @(posedge clock);
    avsAddress <= {idx, 2'b00};
    avsRead <= !wr;
    avsWrite <= wr;
    avsByteenable <= {2'b00, be};
    avsWritedata <= {16'h0000, d};
    do @(posedge clock); while (avsWaitrequest !== 1'b0);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
endtask
task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
    expQ.push_back(exp);
    bus(1'b0, idx, 2'b11, 16'h0000);
endtask
// Model places data, raises ready a cycle later, port reacts next
task automatic send(input logic [15:0] d);
    @(posedge clock);
    sendWord <= d;
    sendReq <= 1'b1;
    @(posedge clock);
    sendReq <= 1'b0;
    repeat (4) @(posedge clock);
endtask
task automatic ack(input logic inA, input logic outA);
    @(posedge clock);
    inIrqAck <= inA;
    outIrqAck <= outA;
    @(posedge clock);
    inIrqAck <= 1'b0;
    outIrqAck <= 1'b0;
endtask
task automatic finishTest;
    $display("compared %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask
// Read data checked at the completion edge, against the oldest note
always @(posedge clock) begin
    if (avsRead && avsWaitrequest === 1'b0) begin
        chk("read data", avsReaddata[15:0], expQ.pop_front());
    end
end
// Whole run is about two hundred cycles; this cuts a hang short
initial begin
    #200000;
    errorCnt++;
    $display("unexpected timeout: expected end of tests, seen hang");
    finishTest;
end
initial begin
    repeat (20) @(posedge clock);
    chk("init in reset", 16'(system_init_out), 16'h0001);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rd(i[2:0], 16'h0000);
    bus(1'b1, 3'h6, 2'b11, 16'hFFFF);
    rd(3'h6, 16'h0000);
    $display("test reset values done");
    rnd = lfsr(rnd);
    w = rnd[15:0];
    bus(1'b1, 3'h0, 2'b11, 16'h4000);
    bus(1'b1, 3'h2, 2'b11, w);
    repeat (5) @(posedge clock);
    chk("word taken", gotWord, w);
    chk("strobes", {loCnt, hiCnt}, 16'h0101);
    chk("out request", 16'(outIrqReq), 16'h0001);
    rd(3'h0, 16'hC000);
    ack(1'b0, 1'b1);
    rd(3'h0, 16'h8000);
    useLineB <= 1'b1;
    slow <= 1'b1;
    rnd = lfsr(rnd);
    bus(1'b1, 3'h2, 2'b01, rnd[15:0]);
    repeat (10) @(posedge clock);
    chk("strobes", {loCnt, hiCnt}, 16'h0201);
    chk("out request", 16'(outIrqReq), 16'h0000);
    rd(3'h2, {w[15:8], rnd[7:0]});
    bus(1'b1, 3'h2, 2'b10, rnd[15:0]);
    repeat (10) @(posedge clock);
    chk("strobes", {loCnt, hiCnt}, 16'h0202);
    rd(3'h2, rnd[15:0]);
    $display("test output done");
    bus(1'b1, 3'h0, 2'b11, 16'h0040);
    rnd = lfsr(rnd);
    w = rnd[15:0];
    send(w);
    chk("in request", 16'(inIrqReq), 16'h0001);
    rd(3'h0, 16'h00C0);
    rd(3'h1, w);
    repeat (2) @(posedge clock);
    chk("read seen", {takenCnt, 7'h00, extDataReady}, 16'h0200);
    ack(1'b1, 1'b0);
    rd(3'h0, 16'h0080);
    $display("test input lines done");
    send(16'h0000);
    bus(1'b1, 3'h3, 2'b01, 16'h0001);
    bus(1'b1, 3'h1, 2'b11, 16'hFFFF);
    rd(3'h1, 16'h0000);
    bus(1'b1, 3'h0, 2'b01, 16'h0040);
    rnd = lfsr(rnd);
    w = rnd[15:0] | 16'h0101;
    send(w);
    chk("bit request", 16'(inIrqReq), 16'h0001);
    send(16'h0000);
    bus(1'b1, 3'h1, 2'b11, w & 16'h00FF);
    rd(3'h1, w & 16'hFF00);
    ack(1'b1, 1'b0);
    bus(1'b1, 3'h3, 2'b01, 16'h0000);
    $display("test buffered bits done");
    bus(1'b1, 3'h0, 2'b11, 16'h2020);
    @(posedge clock);
    chk("forced", {7'h00, inIrqReq, 7'h00, outIrqReq}, 16'h0101);
    rd(3'h0, 16'h0000);
    ack(1'b1, 1'b1);
    $display("test forced requests done");
    bus(1'b1, 3'h0, 2'b11, 16'h4040);
    send(w);
    bus(1'b1, 3'h3, 2'b01, 16'h0002);
    @(posedge clock);
    chk("soft init", 16'(system_init_out), 16'h0001);
    rd(3'h0, 16'h0000);
    chk("requests", {7'h00, inIrqReq, 7'h00, outIrqReq}, 16'h0000);
    $display("test software init done");
    finishTest;
end
endmodule
